// ### hdl/tee_pkg.sv
package tee_pkg;

    // Register offsets (byte addresses on the plain port)
    localparam logic [3:0] ADDR_CONTROL_B = 4'h1;
    localparam logic [3:0] ADDR_EVENT_INPUT_CONTROL = 4'h4;
    localparam logic [3:0] ADDR_INTERRUPT_ENABLE_CONTROL = 4'h5;
    localparam logic [3:0] ADDR_INTERRUPT_FLAG_STATUS = 4'h6;
    localparam logic [3:0] ADDR_STATUS = 4'h7;
    localparam logic [3:0] ADDR_COUNTER_LOW = 4'hA;
    localparam logic [3:0] ADDR_COUNTER_HIGH = 4'hB;
    localparam logic [3:0] ADDR_CAPTURE_COMPARE_VALUE_LOW = 4'hC;
    localparam logic [3:0] ADDR_CAPTURE_COMPARE_VALUE_HIGH = 4'hD;
    localparam logic [3:0] ADDR_ENABLE = 4'h0;

    // Field positions
    localparam int BIT_CAPTURE = 0;
    localparam int BIT_OVERFLOW = 1;
    localparam int BIT_EDGE = 4;
    localparam int BIT_CAPTURE_EVENT_INPUT_ENABLE_EN = 0;
    localparam int BIT_RUN = 0;
    localparam int BIT_ENABLE = 0;

    // Reset values and counter limits
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [15:0] RESET_WORD = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
    localparam logic [7:0] BYTE_BOTTOM = 8'h00;

    typedef enum logic [2:0] {
        MODE_PERIODIC = 3'h0,
        MODE_TIMEOUT = 3'h1,
        MODE_CAPTURE = 3'h2,
        MODE_FREQUENCY = 3'h3,
        MODE_PULSE_WIDTH = 3'h4,
        MODE_FREQ_PULSE = 3'h5,
        MODE_SINGLE_SHOT = 3'h6,
        MODE_PWM8 = 3'h7
    } tee_mode_e;

    // Decoded edge actions
    typedef struct packed {
        logic start;
        logic stop;
        logic restart;
        logic capture;
        logic set_flag;
    } tee_action_s;

    typedef enum logic [1:0] {
        FP_IDLE = 2'b00,
        FP_RUNNING = 2'b01,
        FP_CAPTURED = 2'b10
    } tee_fp_e;

endpackage : tee_pkg

// ### hdl/tee_edge_decoder.sv
`timescale 1ns/10ps
module tee_edge_decoder (
    // Event and configuration
    input wire logic rise_in,
    input wire logic fall_in,
    input wire logic edge_sel_in,
    input wire logic capture_enable_in,
    input wire tee_pkg::tee_mode_e mode_in,
    input wire tee_pkg::tee_fp_e fp_state_in,
    // Decoded action
    output tee_pkg::tee_action_s action_out
);

    logic prim;
    logic secd;

    always_comb begin
        prim = edge_sel_in ? fall_in : rise_in;
        secd = edge_sel_in ? rise_in : fall_in;
        action_out = '0;
        case (mode_in)
            tee_pkg::MODE_PERIODIC: begin
                action_out = '0;
            end
            tee_pkg::MODE_TIMEOUT: begin
                action_out.start = prim;
                action_out.stop = secd;
            end
            tee_pkg::MODE_CAPTURE: begin
                action_out.capture = prim && capture_enable_in;
                action_out.set_flag = prim && capture_enable_in;
            end
            tee_pkg::MODE_FREQUENCY: begin
                action_out.capture = prim && capture_enable_in;
                action_out.restart = prim && capture_enable_in;
                action_out.set_flag = prim && capture_enable_in;
            end
            tee_pkg::MODE_PULSE_WIDTH: begin
                action_out.restart = prim && capture_enable_in;
                action_out.capture = secd && capture_enable_in;
                action_out.set_flag = secd && capture_enable_in;
            end
            tee_pkg::MODE_FREQ_PULSE: begin
                if (capture_enable_in) begin
                    case (fp_state_in)
                        tee_pkg::FP_IDLE: begin
                            action_out.restart = prim;
                        end
                        tee_pkg::FP_RUNNING: begin
                            action_out.capture = secd;
                        end
                        tee_pkg::FP_CAPTURED: begin
                            action_out.stop = prim;
                            action_out.set_flag = prim;
                        end
                        default: begin
                            action_out = '0;
                        end
                    endcase
                end
            end
            tee_pkg::MODE_SINGLE_SHOT: begin
                action_out.start = rise_in || (edge_sel_in && fall_in);
            end
            tee_pkg::MODE_PWM8: begin
                action_out = '0;
            end
            default: begin
                action_out = '0;
            end
        endcase
    end

endmodule : tee_edge_decoder

// ### hdl/tee_timer_event.sv
`timescale 1ns/10ps
// Operation
// - Periodic mode ignores all event edges
// - Timeout mode: edges start and stop counter
// - Capture mode: selected edge captures, sets flag
// - Frequency mode: capture, restart, set flag
// - Pulse-width: one edge restarts, other captures
// - Combined: restart, capture, then stop with flag
// - Capture events used only when enabled
// - Overflow enable gates overflow interrupt
// - Capture enable gates capture interrupt
// - Overflow flag set at count FFFF, or at low-byte top in PWM8
// - Writing one clears overflow flag
// - Capture flag cleared by one or capture read
// - Compare value is top in timer modes
// - PWM8: low byte top, high byte flag
// - Combined mode flag on third edge
// - Three-bit mode field encoding
module tee_timer_event (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Event edges from routing network
    input wire logic event_rise_in,
    input wire logic event_fall_in,
    // Register port
    input wire logic [3:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [7:0] reg_rdata_out,
    // Status
    output logic running_out,
    output logic irq_out
);

    logic enable_q;
    tee_pkg::tee_mode_e mode_q;
    logic edge_sel_q;
    logic capture_flag_bit_en_q;
    logic [1:0] int_enable_q;
    logic [1:0] int_flag_q;
    logic [15:0] count_q;
    logic [15:0] capture_compare_value_q;
    logic run_q;
    tee_pkg::tee_fp_e fp_q;
    logic [7:0] reg_rdata_q;
    logic irq_q;
    tee_pkg::tee_action_s action;

    logic wr_any;
    logic tick;
    logic at_top;
    logic pwm_wrap;
    logic pwm_duty_hit;
    logic overflow_ev;
    logic capture_ev;
    logic capture_flag_bit_mode;
    logic capture_flag_bit_read;

    assign wr_any = reg_write_in;
    assign tick = enable_q && run_q;

    tee_edge_decoder u_decoder (
        .rise_in(event_rise_in),
        .fall_in(event_fall_in),
        .edge_sel_in(edge_sel_q),
        .capture_enable_in(capture_flag_bit_en_q),
        .mode_in(mode_q),
        .fp_state_in(fp_q),
        .action_out(action)
    );

    // Compare against top
    always_comb begin
        at_top = (count_q == capture_compare_value_q);
        pwm_wrap = (count_q[7:0] == capture_compare_value_q[7:0]);
        pwm_duty_hit = (count_q[7:0] == capture_compare_value_q[15:8]);
        capture_flag_bit_mode = (mode_q == tee_pkg::MODE_CAPTURE) || (mode_q == tee_pkg::MODE_FREQUENCY) ||
            (mode_q == tee_pkg::MODE_PULSE_WIDTH) || (mode_q == tee_pkg::MODE_FREQ_PULSE);
        capture_flag_bit_read = reg_read_in && capture_flag_bit_mode &&
            ((reg_addr_in == tee_pkg::ADDR_CAPTURE_COMPARE_VALUE_LOW) || (reg_addr_in == tee_pkg::ADDR_CAPTURE_COMPARE_VALUE_HIGH));
        overflow_ev = 1'b0;
        capture_ev = action.set_flag && enable_q;
        case (mode_q)
            tee_pkg::MODE_PERIODIC, tee_pkg::MODE_TIMEOUT, tee_pkg::MODE_SINGLE_SHOT: begin
                capture_ev = tick && at_top;
                overflow_ev = tick && (count_q == tee_pkg::COUNT_MAX);
            end
            tee_pkg::MODE_PWM8: begin
                capture_ev = tick && pwm_duty_hit;
                overflow_ev = tick && pwm_wrap;
            end
            default: begin
                overflow_ev = tick && (count_q == tee_pkg::COUNT_MAX) && !action.restart;
            end
        endcase
    end

    // Control registers
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            enable_q <= 1'b0;
            mode_q <= tee_pkg::MODE_PERIODIC;
            edge_sel_q <= 1'b0;
            capture_flag_bit_en_q <= 1'b0;
            int_enable_q <= 2'b00;
        end else if (wr_any) begin
            case (reg_addr_in)
                tee_pkg::ADDR_ENABLE: begin
                    enable_q <= reg_wdata_in[tee_pkg::BIT_ENABLE];
                end
                tee_pkg::ADDR_CONTROL_B: begin
                    mode_q <= tee_pkg::tee_mode_e'(reg_wdata_in[2:0]);
                end
                tee_pkg::ADDR_EVENT_INPUT_CONTROL: begin
                    edge_sel_q <= reg_wdata_in[tee_pkg::BIT_EDGE];
                    capture_flag_bit_en_q <= reg_wdata_in[tee_pkg::BIT_CAPTURE_EVENT_INPUT_ENABLE_EN];
                end
                tee_pkg::ADDR_INTERRUPT_ENABLE_CONTROL: begin
                    int_enable_q <= reg_wdata_in[1:0];
                end
                default: begin
                    enable_q <= enable_q;
                end
            endcase
        end
    end

    // Run state and combined-mode sequence
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            run_q <= 1'b0;
            fp_q <= tee_pkg::FP_IDLE;
        end else if (wr_any && reg_addr_in == tee_pkg::ADDR_CONTROL_B) begin
            // Timeout, combined and single-shot wait for a start edge
            run_q <= (reg_wdata_in[2:0] != tee_pkg::MODE_TIMEOUT) &&
                     (reg_wdata_in[2:0] != tee_pkg::MODE_SINGLE_SHOT) &&
                     (reg_wdata_in[2:0] != tee_pkg::MODE_FREQ_PULSE);
            fp_q <= tee_pkg::FP_IDLE;
        end else if (enable_q) begin
            if (action.start || action.restart) begin
                run_q <= 1'b1;
            end else if (action.stop) begin
                run_q <= 1'b0;
            end else if (mode_q == tee_pkg::MODE_SINGLE_SHOT && tick && at_top) begin
                run_q <= 1'b0;
            end
            case (fp_q)
                tee_pkg::FP_IDLE: begin
                    if (action.restart && mode_q == tee_pkg::MODE_FREQ_PULSE) begin
                        fp_q <= tee_pkg::FP_RUNNING;
                    end
                end
                tee_pkg::FP_RUNNING: begin
                    if (action.capture) begin
                        fp_q <= tee_pkg::FP_CAPTURED;
                    end
                end
                tee_pkg::FP_CAPTURED: begin
                    if (action.stop) begin
                        fp_q <= tee_pkg::FP_IDLE;
                    end
                end
                default: begin
                    fp_q <= tee_pkg::FP_IDLE;
                end
            endcase
        end
    end

    // Counter
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            count_q <= tee_pkg::RESET_WORD;
        end else if (wr_any && reg_addr_in == tee_pkg::ADDR_COUNTER_LOW) begin
            count_q[7:0] <= reg_wdata_in;
        end else if (wr_any && reg_addr_in == tee_pkg::ADDR_COUNTER_HIGH) begin
            count_q[15:8] <= reg_wdata_in;
        end else if (enable_q && action.restart) begin
            count_q <= tee_pkg::COUNT_BOTTOM;
        end else if (tick) begin
            if (mode_q == tee_pkg::MODE_PWM8) begin
                count_q[15:8] <= tee_pkg::BYTE_BOTTOM;
                count_q[7:0] <= pwm_wrap ? tee_pkg::BYTE_BOTTOM : count_q[7:0] + 8'h01;
            end else if ((mode_q == tee_pkg::MODE_PERIODIC || mode_q == tee_pkg::MODE_TIMEOUT ||
                          mode_q == tee_pkg::MODE_SINGLE_SHOT) && at_top) begin
                count_q <= tee_pkg::COUNT_BOTTOM;
            end else begin
                count_q <= count_q + 16'h0001;
            end
        end
    end

    // Capture/compare register
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            capture_compare_value_q <= tee_pkg::RESET_WORD;
        end else if (enable_q && action.capture) begin
            capture_compare_value_q <= count_q;
        end else if (wr_any && reg_addr_in == tee_pkg::ADDR_CAPTURE_COMPARE_VALUE_LOW) begin
            capture_compare_value_q[7:0] <= reg_wdata_in;
        end else if (wr_any && reg_addr_in == tee_pkg::ADDR_CAPTURE_COMPARE_VALUE_HIGH) begin
            capture_compare_value_q[15:8] <= reg_wdata_in;
        end
    end

    // Sticky flags, set wins over clear
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            int_flag_q <= 2'b00;
        end else begin
            if (overflow_ev) begin
                int_flag_q[tee_pkg::BIT_OVERFLOW] <= 1'b1;
            end else if (wr_any && reg_addr_in == tee_pkg::ADDR_INTERRUPT_FLAG_STATUS &&
                         reg_wdata_in[tee_pkg::BIT_OVERFLOW]) begin
                int_flag_q[tee_pkg::BIT_OVERFLOW] <= 1'b0;
            end
            if (capture_ev) begin
                int_flag_q[tee_pkg::BIT_CAPTURE] <= 1'b1;
            end else if (capture_flag_bit_read || (wr_any && reg_addr_in == tee_pkg::ADDR_INTERRUPT_FLAG_STATUS &&
                         reg_wdata_in[tee_pkg::BIT_CAPTURE])) begin
                int_flag_q[tee_pkg::BIT_CAPTURE] <= 1'b0;
            end
        end
    end

    // Interrupt output
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= (int_flag_q[tee_pkg::BIT_OVERFLOW] && int_enable_q[tee_pkg::BIT_OVERFLOW]) ||
                     (int_flag_q[tee_pkg::BIT_CAPTURE] && int_enable_q[tee_pkg::BIT_CAPTURE]);
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            reg_rdata_q <= tee_pkg::RESET_BYTE;
        end else if (reg_read_in) begin
            case (reg_addr_in)
                tee_pkg::ADDR_ENABLE: reg_rdata_q <= {7'h00, enable_q};
                tee_pkg::ADDR_CONTROL_B: reg_rdata_q <= {5'h00, mode_q};
                tee_pkg::ADDR_EVENT_INPUT_CONTROL: reg_rdata_q <= {3'h0, edge_sel_q, 3'h0, capture_flag_bit_en_q};
                tee_pkg::ADDR_INTERRUPT_ENABLE_CONTROL: reg_rdata_q <= {6'h00, int_enable_q};
                tee_pkg::ADDR_INTERRUPT_FLAG_STATUS: reg_rdata_q <= {6'h00, int_flag_q};
                tee_pkg::ADDR_STATUS: reg_rdata_q <= {7'h00, run_q};
                tee_pkg::ADDR_COUNTER_LOW: reg_rdata_q <= count_q[7:0];
                tee_pkg::ADDR_COUNTER_HIGH: reg_rdata_q <= count_q[15:8];
                tee_pkg::ADDR_CAPTURE_COMPARE_VALUE_LOW: reg_rdata_q <= capture_compare_value_q[7:0];
                tee_pkg::ADDR_CAPTURE_COMPARE_VALUE_HIGH: reg_rdata_q <= capture_compare_value_q[15:8];
                default: reg_rdata_q <= tee_pkg::RESET_BYTE;
            endcase
        end else begin
            reg_rdata_q <= tee_pkg::RESET_BYTE;
        end
    end

    assign reg_rdata_out = reg_rdata_q;
    assign running_out = run_q;
    assign irq_out = irq_q;

endmodule : tee_timer_event

// ### testbench/tee_timer_event_properties.sv
`timescale 1ns/10ps
module tee_timer_event_properties (
    // Watched ports
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic event_rise_in,
    input wire logic event_fall_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic running_out,
    input wire logic irq_out
);
    logic [2:0] mode_q;
    logic en_q;
    logic sel_q;
    logic [1:0] ie_q;
    logic ev;
    logic go;
    logic cap;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    assign ev = event_rise_in | event_fall_in;
    assign go = en_q & ~reg_write_in;
    assign cap = (mode_q >= 3'h2) && (mode_q <= 3'h5);
    // Shadow of the configuration written over the bus
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mode_q <= 3'h0;
            en_q <= 1'b0;
            sel_q <= 1'b0;
            ie_q <= 2'h0;
        end else if (reg_write_in) begin
            if (reg_addr_in == 4'h1) mode_q <= reg_wdata_in[2:0];
            if (reg_addr_in == 4'h0) en_q <= reg_wdata_in[0];
            if (reg_addr_in == 4'h4) sel_q <= reg_wdata_in[4];
            if (reg_addr_in == 4'h5) ie_q <= reg_wdata_in[1:0];
        end
    end
    rdata_idle_a: assert property (!$past(reg_read_in) |-> reg_rdata_out == 8'h00)
        else $error("read data outside its cycle");
    irq_masked_a: assert property (ie_q == 2'h0 && $past(ie_q) == 2'h0 |-> !irq_out)
        else $error("interrupt with all enables off");
    irq_cause_a: assert property ($rose(irq_out) |-> $past(ie_q) != 2'h0)
        else $error("interrupt rose without enable");
    periodic_ignore_a: assert property (mode_q == 3'h0 && go && ev && running_out |=> running_out)
        else $error("periodic mode reacted to edge");
    timeout_start_a: assert property (mode_q == 3'h1 && go && !running_out &&
        (sel_q ? event_fall_in : event_rise_in) |=> running_out)
        else $error("timeout start edge ignored");
    timeout_stop_a: assert property (mode_q == 3'h1 && go && running_out &&
        (sel_q ? event_rise_in : event_fall_in) |=> !running_out)
        else $error("timeout stop edge ignored");
    single_start_a: assert property (mode_q == 3'h6 && go && !running_out &&
        (event_rise_in || (sel_q && event_fall_in)) |=> running_out)
        else $error("single-shot did not start");
    pwm_ignore_a: assert property (mode_q == 3'h7 && go && ev && running_out |=> running_out)
        else $error("pwm mode reacted to edge");
    capture_flag_bit_read_clear_a: assert property ((reg_read_in && reg_addr_in[3:1] == 3'h6 && cap && !ev) ##1 !ev
        ##1 (reg_read_in && reg_addr_in == 4'h6) |=> !reg_rdata_out[0])
        else $error("capture flag survived capture read");
    cover property (cap && en_q && event_rise_in);
    cover property ($rose(irq_out));
    cover property (mode_q == 3'h5 && $fell(running_out));
endmodule : tee_timer_event_properties

bind tee_timer_event tee_timer_event_properties u_tee_timer_event_properties (.clk_in(clk_in),
    .reset_n_in(reset_n_in), .event_rise_in(event_rise_in), .event_fall_in(event_fall_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
    .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out), .running_out(running_out),
    .irq_out(irq_out));

// ### testbench/tee_event_source.sv
`timescale 1ns/10ps
module tee_event_source (
    // Clock
    input wire logic clk_in,
    // Edge pulses towards the timer
    output logic rise_out,
    output logic fall_out
);
    initial begin
        rise_out = 1'b0;
        fall_out = 1'b0;
    end
    // One-cycle pulse launched just after an edge
    task automatic send(input logic rise, input logic fall);
        @(posedge clk_in);
        rise_out <= rise;
        fall_out <= fall;
        @(posedge clk_in);
        rise_out <= 1'b0;
        fall_out <= 1'b0;
    endtask : send
endmodule : tee_event_source

// ### testbench/tee_timer_event_tb.sv
`timescale 1ns/10ps
module tee_timer_event_tb;
    logic clk_in;
    logic reset_n_in;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr_en;
    logic rd_en;
    logic [7:0] rdata;
    logic rise;
    logic fall;
    logic running;
    logic irq;
    int miscompares;
    int compares;

    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    tee_event_source u_tee_event_source (.clk_in(clk_in), .rise_out(rise), .fall_out(fall));
    tee_timer_event u_tee_timer_event (.clk_in(clk_in), .reset_n_in(reset_n_in), .event_rise_in(rise),
        .event_fall_in(fall), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr_en),
        .reg_read_in(rd_en), .reg_rdata_out(rdata), .running_out(running), .irq_out(irq));

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk_in);
        wr_en <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk_in);
        rd_en <= 1'b0;
        #1;
        cmp(rdata, exp);
    endtask : rd
    task automatic ev(input logic r, input logic f, input logic run_exp);
        u_tee_event_source.send(r, f);
        #1;
        cmp({7'h00, running}, {7'h00, run_exp});
    endtask : ev
    task automatic test_done;
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (5000) @(posedge clk_in);
        miscompares++;
        test_done();
    end

    initial begin
        reset_n_in = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        miscompares = 0;
        compares = 0;
        repeat (2) @(posedge clk_in);
        reset_n_in <= 1'b1;
        rd(4'h5, 8'h00);
        rd(4'h6, 8'h00);
        rd(4'h7, 8'h00);
        wr(4'h3, 8'hFF);
        rd(4'h3, 8'h00);
        // Capture on event
        wr(4'h1, 8'h02);
        wr(4'h4, 8'h01);
        wr(4'h5, 8'h01);
        rd(4'h5, 8'h01);
        wr(4'h0, 8'h01);
        ev(1'b0, 1'b1, 1'b1);
        rd(4'h6, 8'h00);
        wr(4'hB, 8'h00);
        wr(4'hA, 8'h10);
        ev(1'b1, 1'b0, 1'b1);
        @(posedge clk_in);
        #1;
        cmp({7'h00, irq}, 8'h01);
        rd(4'hC, 8'h11);
        rd(4'h6, 8'h00);
        cmp({7'h00, irq}, 8'h00);
        wr(4'h4, 8'h00);
        ev(1'b1, 1'b0, 1'b1);
        rd(4'h6, 8'h00);
        wr(4'h4, 8'h11);
        ev(1'b1, 1'b0, 1'b1);
        rd(4'h6, 8'h00);
        ev(1'b0, 1'b1, 1'b1);
        rd(4'h6, 8'h01);
        wr(4'h6, 8'h01);
        rd(4'h6, 8'h00);
        // Frequency, then pulse width, rising edge selected
        wr(4'h4, 8'h01);
        wr(4'h1, 8'h03);
        ev(1'b1, 1'b0, 1'b1);
        ev(1'b1, 1'b0, 1'b1);
        rd(4'h6, 8'h01);
        rd(4'hC, 8'h01);
        wr(4'h1, 8'h04);
        ev(1'b1, 1'b0, 1'b1);
        ev(1'b0, 1'b1, 1'b1);
        rd(4'h6, 8'h01);
        rd(4'hC, 8'h01);
        // Combined: restart, capture, stop
        wr(4'h1, 8'h05);
        ev(1'b1, 1'b0, 1'b1);
        ev(1'b0, 1'b1, 1'b1);
        rd(4'h6, 8'h00);
        ev(1'b1, 1'b0, 1'b0);
        rd(4'h6, 8'h01);
        for (int s = 0; s < 2; s++) begin
            wr(4'h4, (s != 0) ? 8'h10 : 8'h00);
            wr(4'h1, 8'h01);
            ev(s == 0, s != 0, 1'b1);
            ev(s != 0, s == 0, 1'b0);
        end
        wr(4'hD, 8'h40);
        wr(4'h1, 8'h06);
        ev(1'b0, 1'b1, 1'b1);
        // Pwm: top 8 so period 9, duty 3
        wr(4'hD, 8'h03);
        wr(4'hC, 8'h08);
        wr(4'h1, 8'h07);
        wr(4'h6, 8'h03);
        ev(1'b1, 1'b0, 1'b1);
        ev(1'b0, 1'b1, 1'b1);
        repeat (300) @(posedge clk_in);
        rd(4'h6, 8'h03);
        // Periodic with top at maximum
        wr(4'h1, 8'h00);
        wr(4'hC, 8'hFF);
        wr(4'hD, 8'hFF);
        wr(4'h6, 8'h03);
        wr(4'h5, 8'h02);
        wr(4'hA, 8'hF0);
        wr(4'hB, 8'hFF);
        repeat (30) @(posedge clk_in);
        rd(4'h6, 8'h03);
        cmp({7'h00, irq}, 8'h01);
        wr(4'h6, 8'h00);
        rd(4'h6, 8'h03);
        wr(4'h6, 8'h02);
        rd(4'h6, 8'h01);
        cmp({7'h00, irq}, 8'h00);
        ev(1'b1, 1'b0, 1'b1);
        ev(1'b0, 1'b1, 1'b1);
        test_done();
    end
endmodule : tee_timer_event_tb
